/* File: verilog/cic_pkg.sv */
// cic_pkg: constants and carrier types for the cascaded interrupt compatibility block
package cic_pkg;
    localparam int unsigned NUM_LINES = 8;
    localparam logic [2:0] CASCADE_INPUT = 3'h2;
    localparam logic [2:0] SLAVE_NINE_INPUT = 3'h1;
    localparam logic [7:0] MASTER_VEC_BASE = 8'h08;
    localparam logic [7:0] SLAVE_VEC_BASE = 8'h70;
    localparam logic [15:0] REARM_BASE_A = 16'h02f0;
    localparam logic [15:0] REARM_BASE_B = 16'h06f0;
    localparam logic [15:0] REARM_MASK = 16'hfff0;
    localparam logic [15:0] PROGRESS_ADDR = 16'h0078;
    localparam logic [15:0] PROGRESS_CLR_ADDR = 16'h0079;
    localparam logic [15:0] EOI_MASTER_ADDR = 16'h0020;
    localparam logic [15:0] EOI_SLAVE_ADDR = 16'h00a0;
    localparam logic [7:0] EOI_CODE = 8'h20;
    localparam logic PROGRESS_CLEAR_ON_READ = 1'b1;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cic_io_t;

    typedef struct packed {
        logic ack;
        logic [7:0] vector;
    } cic_inta_t;

    typedef struct packed {
        logic [NUM_LINES-1:0] irr;
        logic [NUM_LINES-1:0] isr;
        logic [NUM_LINES-1:0] prev;
    } cic_ctl_t;

    typedef struct packed {
        cic_ctl_t mst;
        cic_ctl_t slv;
        logic [15:0] s1_mst;
        logic [15:0] s2_mst;
        logic [15:0] s1_slv;
        logic [15:0] s2_slv;
        logic s1_casc;
        logic s2_casc;
        logic progress;
        logic [7:0] rdata;
        logic rvalid;
        logic rearm_seen;
    } cic_state_t;
endpackage : cic_pkg

/* File: verilog/cic_top.sv */
// cic_top: cascaded legacy interrupt controller pair with compatibility behaviour
// Operation
// - pci inputs pend on level, isa inputs pend on rising edge.
// - end-of-interrupt clears the highest-priority in-service bit of that controller.
// - level input still high at end-of-interrupt becomes pending again.
// - channel cascade request routes to slave input nine, vector 71h.
// - interrupt-in-progress latch readable by io; cleared by read or explicit reset.
// - re-arm port accesses at 02Fx or 06Fx accepted without disturbing interrupts.
`timescale 1ns/1ns
module cic_top
    import cic_pkg::*;
#(
    parameter logic [NUM_LINES-1:0] MASTER_LEVEL = 8'h00,
    parameter logic [NUM_LINES-1:0] SLAVE_LEVEL = 8'h00
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] irq_pin,
    input wire logic legacy_cascade_request,
    input wire cic_pkg::cic_io_t io,
    input wire logic inta,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    output logic cpu_intr,
    output cic_pkg::cic_inta_t inta_rsp,
    output logic rearm_seen
);
    import cic_pkg::*;

    initial begin
        if (NUM_LINES != 8) $error("cic_top: controllers have eight lines");
        if ($bits(irq_pin) != 2 * NUM_LINES) $error("cic_top: one pin per controller input");
    end

    cic_state_t q, d;

    // lowest index wins, as on the classic pair; there is no rotation or masking
    function automatic logic [NUM_LINES-1:0] top_bit(input logic [NUM_LINES-1:0] v);
        logic [NUM_LINES-1:0] r;
        r = '0;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (v[i]) r = '0;
            if (v[i]) r[i] = 1'b1;
        end
        return r;
    endfunction : top_bit

    function automatic logic [2:0] enc(input logic [NUM_LINES-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (v[i]) r = 3'(i);
        end
        return r;
    endfunction : enc

    logic [NUM_LINES-1:0] m_req, s_req, m_ready, s_ready, m_grant, s_grant;
    logic s_out;
    logic wr_eoi_m, wr_eoi_s, rd_prog, clr_prog, is_rearm;

    always_comb begin
        // slave pins sit above the master pins on the shared request bus
        s_req = q.s2_slv[NUM_LINES +: NUM_LINES];
        s_req[SLAVE_NINE_INPUT] = s_req[SLAVE_NINE_INPUT] | q.s2_casc;
        s_ready = q.slv.irr & ~q.slv.isr;
        s_out = |s_ready;
        m_req = q.s2_mst[NUM_LINES-1:0];
        m_req[CASCADE_INPUT] = s_out;
        m_ready = q.mst.irr & ~q.mst.isr;
        m_grant = top_bit(m_ready);
        s_grant = top_bit(s_ready);
    end

    // any other code written to a command port is ignored, so stray writes cannot end a service
    assign wr_eoi_m = io.wr && io.addr == EOI_MASTER_ADDR && io.wdata == EOI_CODE;
    assign wr_eoi_s = io.wr && io.addr == EOI_SLAVE_ADDR && io.wdata == EOI_CODE;
    assign rd_prog = io.rd && io.addr == PROGRESS_ADDR;
    assign clr_prog = io.wr && io.addr == PROGRESS_CLR_ADDR;
    assign is_rearm = (io.rd || io.wr) && ((io.addr & REARM_MASK) == REARM_BASE_A
                      || (io.addr & REARM_MASK) == REARM_BASE_B);

    // next state of one controller; a grant consumes an edge request so it is served once,
    // while a level request keeps pending for as long as its pin stays high
    function automatic cic_ctl_t step(input cic_ctl_t c, input logic [NUM_LINES-1:0] req,
                                      input logic [NUM_LINES-1:0] lvl, input logic eoi,
                                      input logic [NUM_LINES-1:0] grant);
        cic_ctl_t n;
        logic [NUM_LINES-1:0] edge_v;
        n = c;
        edge_v = req & ~c.prev;
        n.irr = (c.irr & ~lvl) | (lvl & req) | (edge_v & ~lvl);
        if (eoi) n.isr = c.isr & ~top_bit(c.isr);
        n.irr = n.irr | (lvl & req);
        n.isr = n.isr | grant;
        n.irr = n.irr & ~(grant & ~lvl);
        n.prev = req;
        return n;
    endfunction : step

    always_comb begin
        logic casc_ack;
        casc_ack = inta && m_grant[CASCADE_INPUT];
        d = q;
        // pins and the channel cascade line are asynchronous, so each passes two flops
        d.s1_mst = irq_pin;
        d.s2_mst = q.s1_mst;
        d.s1_slv = irq_pin;
        d.s2_slv = q.s1_slv;
        d.s1_casc = legacy_cascade_request;
        d.s2_casc = q.s1_casc;
        d.mst = step(q.mst, m_req, MASTER_LEVEL, wr_eoi_m,
                     inta ? m_grant : '0);
        d.slv = step(q.slv, s_req, SLAVE_LEVEL, wr_eoi_s,
                     casc_ack ? s_grant : '0);
        // progress latch
        // acknowledge wins over a clear in the same cycle, so no service goes unseen
        if (inta) d.progress = 1'b1;
        else if (clr_prog || (rd_prog && PROGRESS_CLEAR_ON_READ)) d.progress = 1'b0;
        d.rvalid = io.rd;
        d.rdata = '0;
        if (rd_prog) d.rdata = {7'h00, q.progress};
        d.rearm_seen = is_rearm;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign io_rdata = q.rdata;
    assign io_rvalid = q.rvalid;
    assign rearm_seen = q.rearm_seen;
    // no mask registers: every ready master request reaches the processor
    assign cpu_intr = |m_ready;
    always_comb begin
        inta_rsp.ack = inta;
        if (m_grant[CASCADE_INPUT]) inta_rsp.vector = SLAVE_VEC_BASE | {5'h00, enc(s_grant)};
        else inta_rsp.vector = MASTER_VEC_BASE | {5'h00, enc(m_grant)};
    end

    // single-cycle conditions are named once so the properties read as rules
    sequence mst_eoi_seq;
        wr_eoi_m && !inta && q.mst.isr != '0;
    endsequence
    sequence slv_eoi_seq;
        wr_eoi_s && !inta && q.slv.isr != '0;
    endsequence
    sequence casc_ack_seq;
        inta && m_grant[CASCADE_INPUT] && s_out;
    endsequence
    sequence slv_in_service_seq;
        q.slv.isr != '0;
    endsequence

    chk_eoi_clears_isr: assert property (@(posedge clk) disable iff (!arst_n)
        mst_eoi_seq |=> q.mst.isr == ($past(q.mst.isr) & ~top_bit($past(q.mst.isr))))
        else $error("master eoi did not clear top in-service bit");
    chk_slave_eoi: assert property (@(posedge clk) disable iff (!arst_n)
        slv_eoi_seq |=> q.slv.isr == ($past(q.slv.isr) & ~top_bit($past(q.slv.isr))))
        else $error("slave eoi did not clear top in-service bit");
    chk_casc_service: assert property (@(posedge clk) disable iff (!arst_n)
        casc_ack_seq |=> slv_in_service_seq)
        else $error("cascade acknowledge left the slave idle");
    chk_level_drop: assert property (@(posedge clk) disable iff (!arst_n)
        (~m_req & MASTER_LEVEL) != '0 |=> (q.mst.irr & $past(~m_req & MASTER_LEVEL)) == '0)
        else $error("released level request still pending");
    chk_edge_once: assert property (@(posedge clk) disable iff (!arst_n)
        inta && (m_grant & ~MASTER_LEVEL) != '0 |=> (q.mst.irr & $past(m_grant & ~MASTER_LEVEL)) == '0)
        else $error("served edge request pending again");
    chk_progress_read: assert property (@(posedge clk) disable iff (!arst_n)
        rd_prog |=> io_rvalid && io_rdata[0] == $past(q.progress))
        else $error("progress read returned the wrong value");

    chk_level_repend: assert property (@(posedge clk) disable iff (!arst_n)
        (m_req & MASTER_LEVEL) != '0 |=> (q.mst.irr & $past(m_req & MASTER_LEVEL)) == $past(m_req & MASTER_LEVEL))
        else $error("held level request not pending");
    chk_edge_pend: assert property (@(posedge clk) disable iff (!arst_n)
        (m_req & ~q.mst.prev & ~MASTER_LEVEL) != '0 && !inta
        |=> (q.mst.irr & $past(m_req & ~q.mst.prev & ~MASTER_LEVEL)) != '0)
        else $error("edge request lost");
    chk_cascade_route: assert property (@(posedge clk) disable iff (!arst_n)
        q.s2_casc && !q.slv.prev[SLAVE_NINE_INPUT] && !inta |=> q.slv.irr[SLAVE_NINE_INPUT])
        else $error("cascade request not on slave nine");
    chk_slave_present: assert property (@(posedge clk) disable iff (!arst_n)
        s_out && !q.mst.prev[CASCADE_INPUT] && !inta |=> q.mst.irr[CASCADE_INPUT])
        else $error("slave output not on master cascade");
    chk_progress_set: assert property (@(posedge clk) disable iff (!arst_n)
        inta |=> q.progress)
        else $error("progress latch not set");
    chk_progress_clr: assert property (@(posedge clk) disable iff (!arst_n)
        clr_prog && !inta |=> !q.progress)
        else $error("progress latch not cleared");
    chk_rearm_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        is_rearm && !inta ##1 q.rearm_seen |-> q.mst.isr == $past(q.mst.isr))
        else $error("re-arm access disturbed in-service state");
endmodule : cic_top

/* File: testbench/cic_host_model.sv */
// cic_host_model: host processor and service software facing the block
`timescale 1ns/1ns
module cic_host_model
    import cic_pkg::*;
#(
    parameter int IO_DELAY = 2
) (
    input wire logic clk,
    input wire cic_pkg::cic_inta_t inta_rsp,
    input wire logic [7:0] io_rdata,
    output cic_pkg::cic_io_t io,
    output logic inta
);
    initial begin
        io = '0;
        inta = 1'b0;
    end
    task automatic access(input logic rd, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] got);
        @(posedge clk);
        #1 io = '{rd: rd, wr: !rd, addr: a, wdata: wd};
        @(posedge clk);
        #1 io = '0;
        got = io_rdata;
    endtask : access
    // vector is combinational, so it is read inside the acknowledge cycle
    task automatic ack(output logic [7:0] vec);
        @(posedge clk);
        #1 inta = 1'b1;
        // a missing acknowledge answer reads as ff, which no vector uses
        #1 vec = inta_rsp.ack ? inta_rsp.vector : 8'hff;
        @(posedge clk);
        #1 inta = 1'b0;
    endtask : ack
    task automatic eoi(input logic to_slave);
        logic [7:0] d;
        access(1'b0, to_slave ? EOI_SLAVE_ADDR : EOI_MASTER_ADDR, EOI_CODE, d);
    endtask : eoi
    task automatic io_wait();
        repeat (IO_DELAY) @(posedge clk);
    endtask : io_wait
endmodule : cic_host_model

/* File: testbench/tb_cic_top.sv */
// tb_cic_top: self-checking bench for the cascaded interrupt block
`timescale 1ns/1ns
module tb_cic_top;
    import cic_pkg::*;
    logic clk, arst_n, legacy_cascade_request, inta, io_rvalid, cpu_intr, rearm_seen;
    logic [15:0] irq_pin;
    logic [7:0] io_rdata, v;
    cic_io_t io;
    cic_inta_t inta_rsp;
    int mismatches, compares;
    // pin 4 is the only level input, the rest stay edge
    cic_top #(.MASTER_LEVEL(8'h10), .SLAVE_LEVEL(8'h00)) cic_top_i (.clk(clk), .arst_n(arst_n),
        .irq_pin(irq_pin), .legacy_cascade_request(legacy_cascade_request), .io(io), .inta(inta),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .cpu_intr(cpu_intr), .inta_rsp(inta_rsp),
        .rearm_seen(rearm_seen));
    cic_host_model host_i (.clk(clk), .inta_rsp(inta_rsp), .io_rdata(io_rdata), .io(io), .inta(inta));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // bounded wait; a miss ends the run
    task automatic wait_intr();
        for (int n = 0; n < 8 && cpu_intr !== 1'b1; n++) @(posedge clk) #2;
        cmp("cpu_intr", 8'h01, {7'h0, cpu_intr});
        if (cpu_intr !== 1'b1) results();
    endtask : wait_intr
    task automatic quiet();
        repeat (6) @(posedge clk);
        #2 cmp("cpu_intr", 8'h00, {7'h0, cpu_intr});
    endtask : quiet
    task automatic test_edge();
        #0 irq_pin[3] = 1'b1;
        wait_intr();
        host_i.ack(v);
        cmp("vector", 8'h0b, v);
        host_i.access(1'b1, PROGRESS_ADDR, 8'h00, v);
        cmp("progress", 8'h01, v);
        cmp("io_rvalid", 8'h01, {7'h0, io_rvalid});
        host_i.access(1'b1, PROGRESS_ADDR, 8'h00, v);
        cmp("progress", 8'h00, v);
        host_i.eoi(1'b0);
        quiet();
        irq_pin[3] = 1'b0;
        $display("test edge done");
    endtask : test_edge
    task automatic test_rearm();
        irq_pin[5] = 1'b1;
        wait_intr();
        for (int i = 0; i < 2; i++) begin
            host_i.access(i[0], (i[0] ? REARM_BASE_B : REARM_BASE_A) | 16'h0005, 8'h00, v);
            cmp("rearm_seen", 8'h01, {7'h0, rearm_seen});
            cmp("io_rvalid", {7'h0, i[0]}, {7'h0, io_rvalid});
            cmp("io_rdata", 8'h00, v);
            cmp("cpu_intr", 8'h01, {7'h0, cpu_intr});
        end
        host_i.ack(v);
        cmp("vector", 8'h0d, v);
        host_i.eoi(1'b0);
        irq_pin[5] = 1'b0;
        $display("test rearm done");
    endtask : test_rearm
    task automatic test_level();
        irq_pin[4] = 1'b1;
        wait_intr();
        host_i.ack(v);
        host_i.eoi(1'b0);
        wait_intr();
        host_i.ack(v);
        cmp("vector", 8'h0c, v);
        irq_pin[4] = 1'b0;
        host_i.io_wait();
        host_i.eoi(1'b0);
        host_i.io_wait();
        quiet();
        $display("test level done");
    endtask : test_level
    task automatic test_cascade();
        legacy_cascade_request = 1'b1;
        wait_intr();
        host_i.ack(v);
        cmp("vector", 8'h71, v);
        host_i.access(1'b0, PROGRESS_CLR_ADDR, 8'h00, v);
        host_i.access(1'b1, PROGRESS_ADDR, 8'h00, v);
        cmp("progress", 8'h00, v);
        // slave end, drop request, master end
        host_i.eoi(1'b1);
        legacy_cascade_request = 1'b0;
        host_i.io_wait();
        host_i.eoi(1'b0);
        quiet();
        $display("test cascade done");
    endtask : test_cascade
    // every slave pin reaches the processor through the master cascade input
    task automatic test_slave();
        for (int i = 0; i < NUM_LINES; i++) begin
            irq_pin[NUM_LINES + i] = 1'b1;
            wait_intr();
            host_i.ack(v);
            cmp("vector", SLAVE_VEC_BASE + 8'(i), v);
            host_i.eoi(1'b1);
            irq_pin[NUM_LINES + i] = 1'b0;
            host_i.eoi(1'b0);
            quiet();
        end
        $display("test slave done");
    endtask : test_slave
    initial begin
        arst_n = 1'b0;
        irq_pin = '0;
        legacy_cascade_request = 1'b0;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        cmp("vector", 8'h08, inta_rsp.vector);
        test_edge();
        test_rearm();
        test_level();
        test_cascade();
        test_slave();
        results();
    end
endmodule : tb_cic_top
